//--- rtl/sapf_pkg.sv
package sapf_pkg;

    // ==========================================================
    // Register map
    localparam logic [15:0] RESULT_ADDR = 16'hff08;
    localparam logic [15:0] RESULT_HI_ADDR = 16'hff09;
    localparam logic [15:0] MODE_ADDR = 16'hff28;
    localparam logic [15:0] CHAN_ADDR = 16'hff29;
    localparam logic [15:0] CMPMODE_ADDR = 16'hff2a;
    localparam logic [15:0] THRESH_ADDR = 16'hff2b;

    // ==========================================================
    // Field layout and reset values
    localparam int MODE_RUN_BIT = 7;
    localparam int MODE_TIME_LSB = 3;
    localparam int MODE_REF_BIT = 0;
    localparam logic [7:0] MODE_MASK = 8'hb9;
    localparam logic [7:0] CHAN_MASK = 8'h07;
    localparam int CMPMODE_EN_BIT = 7;
    localparam int CMPMODE_POL_BIT = 6;
    localparam logic [7:0] CMPMODE_MASK = 8'hc0;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] CHAN_RESET = 8'h00;
    localparam logic [7:0] CMPMODE_RESET = 8'h00;
    localparam logic [7:0] THRESH_RESET = 8'h00;
    localparam logic [9:0] RESULT_RESET = 10'h000;
    localparam int RES_BITS = 10;
    localparam int RES_SHIFT = 6;

    // ==========================================================
    // Conversion timing in main-clock periods
    localparam int PERIOD_000 = 288;
    localparam int PERIOD_001 = 240;
    localparam int PERIOD_010 = 192;
    localparam int PERIOD_100 = 144;
    localparam int PERIOD_101 = 120;
    localparam int PERIOD_110 = 96;
    localparam int TIME_UNITS = 24;
    localparam int SAMPLE_UNITS = TIME_UNITS - RES_BITS;
    localparam int UNIT_W = 4;

    // Unit length per time code, zero for a prohibited code
    function automatic logic [UNIT_W-1:0] unit_of(input logic [2:0] code);
        unique case (code)
            3'h0: unit_of = UNIT_W'(PERIOD_000 / TIME_UNITS);
            3'h1: unit_of = UNIT_W'(PERIOD_001 / TIME_UNITS);
            3'h2: unit_of = UNIT_W'(PERIOD_010 / TIME_UNITS);
            3'h4: unit_of = UNIT_W'(PERIOD_100 / TIME_UNITS);
            3'h5: unit_of = UNIT_W'(PERIOD_101 / TIME_UNITS);
            3'h6: unit_of = UNIT_W'(PERIOD_110 / TIME_UNITS);
            default: unit_of = '0;
        endcase
    endfunction

    // ==========================================================
    // Types
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_SAMPLE, SEQ_TRIAL} sapf_state_e;

    typedef struct packed {
        logic we;
        logic word;
        logic [15:0] addr;
        logic [15:0] wdata;
    } sapf_req_s;

endpackage

//--- rtl/sapf_control.sv
`timescale 1ns/1ps
module sapf_control #(
    parameter int CHANNELS = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // CPU register access
    input wire logic cpu_req,
    input wire sapf_pkg::sapf_req_s cpu_cmd,
    output logic cpu_ack_q,
    output logic cpu_wait_q,
    output logic [15:0] cpu_rdata_q,
    // Analog front end
    input wire logic cmp_ge,
    output logic sample_q,
    output logic hold_q,
    output logic [2:0] channel_q,
    output logic [9:0] tap_q,
    output logic reference_enable_q,
    // Event
    output logic conversion_done_irq_q
);

    // ==========================================================
    // Elaboration checks
    if (CHANNELS != 8) begin : g_bad_channels
        $error("sapf_control serves exactly eight channels");
    end
    if (sapf_pkg::SAMPLE_UNITS < 1) begin : g_bad_units
        $error("sapf_control needs a positive sampling period");
    end

    // ==========================================================
    // Register state
    logic [7:0] mode_q;
    logic [7:0] cmpmode_q;
    logic [7:0] thresh_q;
    logic [9:0] result_q;
    logic pend_q;

    // ==========================================================
    // Bus decode
    logic take;
    logic hit_mode;
    logic hit_chan;
    logic hit_cmpmode;
    logic hit_thresh;
    logic hit_result;
    logic reg_wr;
    logic needs_wait;
    logic [7:0] mode_next;
    logic [7:0] chan_wdata;
    logic [15:0] rdata_d;

    assign take = cpu_req && !pend_q && !cpu_ack_q;
    assign hit_mode = cpu_cmd.addr == sapf_pkg::MODE_ADDR;
    assign hit_chan = (cpu_cmd.addr == sapf_pkg::CHAN_ADDR)
                      || (cpu_cmd.word && hit_mode);
    assign hit_cmpmode = cpu_cmd.addr == sapf_pkg::CMPMODE_ADDR;
    assign hit_thresh = (cpu_cmd.addr == sapf_pkg::THRESH_ADDR) && !cpu_cmd.word;
    assign hit_result = (cpu_cmd.addr == sapf_pkg::RESULT_ADDR) && cpu_cmd.word;
    assign reg_wr = take && cpu_cmd.we && (hit_mode || hit_chan || hit_cmpmode || hit_thresh);
    assign needs_wait = cpu_cmd.we ? reg_wr : hit_result;
    assign chan_wdata = (cpu_cmd.word && hit_mode) ? cpu_cmd.wdata[15:8] : cpu_cmd.wdata[7:0];
    assign mode_next = (take && cpu_cmd.we && hit_mode)
                       ? (cpu_cmd.wdata[7:0] & sapf_pkg::MODE_MASK) : mode_q;

    always_comb
    begin
        rdata_d = 16'h0000;
        if (hit_result)
        begin
            rdata_d = {result_q, 6'h00};
        end
        else if (cpu_cmd.word && hit_mode)
        begin
            rdata_d = {5'h00, channel_q, mode_q};
        end
        else if (cpu_cmd.word && hit_cmpmode)
        begin
            rdata_d = {thresh_q, cmpmode_q};
        end
        else if (hit_mode)
        begin
            rdata_d = {8'h00, mode_q};
        end
        else if (hit_chan)
        begin
            rdata_d = {13'h0000, channel_q};
        end
        else if (hit_cmpmode)
        begin
            rdata_d = {8'h00, cmpmode_q};
        end
        else if (cpu_cmd.addr == sapf_pkg::THRESH_ADDR)
        begin
            rdata_d = {8'h00, thresh_q};
        end
    end

    // ==========================================================
    // Bus handshake with optional wait cycle
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            pend_q <= 1'b0;
            cpu_wait_q <= 1'b0;
            cpu_ack_q <= 1'b0;
            cpu_rdata_q <= 16'h0000;
        end
        else
        begin
            cpu_ack_q <= 1'b0;
            if (pend_q)
            begin
                pend_q <= 1'b0;
                cpu_wait_q <= 1'b0;
                cpu_ack_q <= 1'b1;
            end
            else if (take)
            begin
                cpu_rdata_q <= cpu_cmd.we ? 16'h0000 : rdata_d;
                pend_q <= needs_wait;
                cpu_wait_q <= needs_wait;
                cpu_ack_q <= !needs_wait;
            end
        end
    end

    // ==========================================================
    // Software registers
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            mode_q <= sapf_pkg::MODE_RESET;
            channel_q <= sapf_pkg::CHAN_RESET[2:0];
            cmpmode_q <= sapf_pkg::CMPMODE_RESET;
            thresh_q <= sapf_pkg::THRESH_RESET;
            reference_enable_q <= 1'b0;
        end
        else if (take && cpu_cmd.we)
        begin
            mode_q <= mode_next;
            reference_enable_q <= mode_next[sapf_pkg::MODE_REF_BIT];
            if (hit_chan)
            begin
                channel_q <= chan_wdata[2:0] & sapf_pkg::CHAN_MASK[2:0];
            end
            if (hit_cmpmode)
            begin
                cmpmode_q <= cpu_cmd.wdata[7:0] & sapf_pkg::CMPMODE_MASK;
            end
            if (hit_thresh)
            begin
                thresh_q <= cpu_cmd.wdata[7:0];
            end
        end
    end

    // ==========================================================
    // Sequencer
    sapf_pkg::sapf_state_e state_q;
    logic [sapf_pkg::UNIT_W-1:0] unit_len_q;
    logic [sapf_pkg::UNIT_W-1:0] unit_cnt_q;
    logic [4:0] seg_cnt_q;
    logic [3:0] bit_idx_q;
    logic [9:0] approx_q;
    logic [sapf_pkg::UNIT_W-1:0] unit_next;
    logic start_conv;
    logic tick;
    logic sample_end;
    logic trial_end;
    logic conv_end;

    assign unit_next = sapf_pkg::unit_of(mode_next[sapf_pkg::MODE_TIME_LSB +: 3]);
    assign start_conv = reg_wr && mode_next[sapf_pkg::MODE_RUN_BIT] && (unit_next != '0);
    assign tick = unit_cnt_q == '0;
    assign sample_end = (state_q == sapf_pkg::SEQ_SAMPLE) && tick && (seg_cnt_q == 5'h00);
    assign trial_end = (state_q == sapf_pkg::SEQ_TRIAL) && tick;
    assign conv_end = trial_end && (bit_idx_q == 4'h0) && !reg_wr;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= sapf_pkg::SEQ_IDLE;
            unit_len_q <= '0;
            unit_cnt_q <= '0;
            seg_cnt_q <= 5'h00;
            bit_idx_q <= 4'h0;
            sample_q <= 1'b0;
            hold_q <= 1'b0;
        end
        else if (reg_wr)
        begin
            // Any register write aborts; restart from sampling if run stays set and the time code is not prohibited
            state_q <= start_conv ? sapf_pkg::SEQ_SAMPLE : sapf_pkg::SEQ_IDLE;
            unit_len_q <= unit_next;
            unit_cnt_q <= unit_next - sapf_pkg::UNIT_W'(1);
            seg_cnt_q <= 5'(sapf_pkg::SAMPLE_UNITS - 1);
            sample_q <= start_conv;
            hold_q <= 1'b0;
        end
        else
        begin
            unit_cnt_q <= tick ? unit_len_q - sapf_pkg::UNIT_W'(1)
                               : unit_cnt_q - sapf_pkg::UNIT_W'(1);
            unique case (state_q)
                sapf_pkg::SEQ_IDLE:
                begin
                    unit_cnt_q <= '0;
                end
                sapf_pkg::SEQ_SAMPLE:
                begin
                    if (sample_end)
                    begin
                        state_q <= sapf_pkg::SEQ_TRIAL;
                        bit_idx_q <= 4'(sapf_pkg::RES_BITS - 1);
                        sample_q <= 1'b0;
                        hold_q <= 1'b1;
                    end
                    else if (tick)
                    begin
                        seg_cnt_q <= seg_cnt_q - 5'h01;
                    end
                end
                sapf_pkg::SEQ_TRIAL:
                begin
                    if (trial_end && bit_idx_q == 4'h0)
                    begin
                        // Next conversion follows at once
                        state_q <= sapf_pkg::SEQ_SAMPLE;
                        seg_cnt_q <= 5'(sapf_pkg::SAMPLE_UNITS - 1);
                        sample_q <= 1'b1;
                        hold_q <= 1'b0;
                    end
                    else if (trial_end)
                    begin
                        bit_idx_q <= bit_idx_q - 4'h1;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Approximation, result and interrupt
    logic [9:0] decided;
    logic [9:0] trial_bit;
    logic [7:0] res_hi;
    logic meets;

    assign trial_bit = 10'h001 << bit_idx_q;
    assign decided = cmp_ge ? approx_q : (approx_q & ~trial_bit);
    assign res_hi = decided[9:2];
    assign meets = cmpmode_q[sapf_pkg::CMPMODE_POL_BIT] ? (res_hi < thresh_q)
                                                       : (res_hi >= thresh_q);

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            approx_q <= 10'h000;
            tap_q <= 10'h000;
            result_q <= sapf_pkg::RESULT_RESET;
            conversion_done_irq_q <= 1'b0;
        end
        else
        begin
            conversion_done_irq_q <= 1'b0;
            if (sample_end && !reg_wr)
            begin
                approx_q <= 10'h200;
                tap_q <= 10'h200;
            end
            else if (conv_end)
            begin
                result_q <= decided;
                approx_q <= 10'h000;
                tap_q <= 10'h000;
                conversion_done_irq_q <= !cmpmode_q[sapf_pkg::CMPMODE_EN_BIT] || meets;
            end
            else if (trial_end && !reg_wr)
            begin
                approx_q <= decided | (trial_bit >> 1);
                tap_q <= decided | (trial_bit >> 1);
            end
        end
    end

endmodule // sapf_control

//--- dv/sapf_control_props.sv
`timescale 1ns/1ps
module sapf_control_props #(
    parameter int CHANNELS = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Register access
    input wire logic cpu_req,
    input wire sapf_pkg::sapf_req_s cpu_cmd,
    input wire logic cpu_ack_q,
    input wire logic cpu_wait_q,
    input wire logic [15:0] cpu_rdata_q,
    // Front end
    input wire logic cmp_ge,
    input wire logic sample_q,
    input wire logic hold_q,
    input wire logic [2:0] channel_q,
    input wire logic [9:0] tap_q,
    input wire logic reference_enable_q,
    input wire logic conversion_done_irq_q
);
    // ==========
    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);
    a_irq_one_pulse: assert property (conversion_done_irq_q |=> !conversion_done_irq_q)
        else $error("done pulse longer than one cycle");
    a_sample_hold_apart: assert property (!(sample_q && hold_q))
        else $error("sampling and holding together");
    a_first_tap_half: assert property ($fell(sample_q) && hold_q |-> tap_q == 10'h200)
        else $error("first trial tap not half scale");
    a_irq_after_hold: assert property (conversion_done_irq_q |-> $past(hold_q))
        else $error("done pulse without trials");
    a_irq_resample: assert property (conversion_done_irq_q |-> sample_q && !hold_q)
        else $error("no new sampling after conversion end");
    a_wait_then_ack: assert property (cpu_wait_q |=> cpu_ack_q && !cpu_wait_q)
        else $error("ack missing after wait cycle");
    a_result_wait: assert property ($rose(cpu_req) && !cpu_cmd.we && cpu_cmd.word
        && cpu_cmd.addr == sapf_pkg::RESULT_ADDR |=> cpu_wait_q ##1 cpu_ack_q)
        else $error("result read without wait cycle");
    a_write_wait: assert property ($rose(cpu_req) && cpu_cmd.we && !cpu_cmd.word
        && cpu_cmd.addr == sapf_pkg::THRESH_ADDR |=> cpu_wait_q ##1 cpu_ack_q)
        else $error("threshold write without wait cycle");
endmodule // sapf_control_props

bind sapf_control sapf_control_props #(.CHANNELS(CHANNELS)) props_u (
    .clock(clock), .nrst(nrst), .cpu_req(cpu_req), .cpu_cmd(cpu_cmd),
    .cpu_ack_q(cpu_ack_q), .cpu_wait_q(cpu_wait_q), .cpu_rdata_q(cpu_rdata_q),
    .cmp_ge(cmp_ge), .sample_q(sample_q), .hold_q(hold_q), .channel_q(channel_q),
    .tap_q(tap_q), .reference_enable_q(reference_enable_q),
    .conversion_done_irq_q(conversion_done_irq_q));

//--- dv/sapf_analog_model.sv
`timescale 1ns/1ps
module sapf_analog_model (
    // Clock and levels
    input wire logic clock,
    input wire logic [79:0] levels,
    // Front end
    input wire logic [2:0] channel_q,
    input wire logic [9:0] tap_q,
    input wire logic sample_q,
    input wire logic hold_q,
    output logic cmp_ge
);
    logic [9:0] held_q;
    logic flip_q = 1'b0;
    always @(posedge clock)
    begin
        flip_q <= !flip_q;
        if (sample_q)
            held_q <= levels[channel_q * 10 +: 10];
    end
    // Noise while not holding
    assign cmp_ge = hold_q ? held_q >= tap_q : flip_q;
endmodule // sapf_analog_model

//--- dv/test_sapf_control.sv
`timescale 1ns/1ps
module test_sapf_control;
    // ==========
    // Signals
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic cpu_req = 1'b0;
    sapf_pkg::sapf_req_s cpu_cmd = '0;
    logic cpu_ack_q, cpu_wait_q, cmp_ge, sample_q, hold_q, ref_q, irq;
    logic [15:0] cpu_rdata_q, rdat;
    logic [2:0] channel_q;
    logic [9:0] tap_q;
    logic [79:0] levels = '0;
    int cyc = 0;
    int t_take;
    int miscompares = 0;
    int n_checks = 0;
    always #20 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;
    sapf_control #(.CHANNELS(8)) dut_u (.clock(clock), .nrst(nrst), .cpu_req(cpu_req),
        .cpu_cmd(cpu_cmd), .cpu_ack_q(cpu_ack_q), .cpu_wait_q(cpu_wait_q),
        .cpu_rdata_q(cpu_rdata_q), .cmp_ge(cmp_ge), .sample_q(sample_q), .hold_q(hold_q),
        .channel_q(channel_q), .tap_q(tap_q), .reference_enable_q(ref_q),
        .conversion_done_irq_q(irq));
    sapf_analog_model model_u (.clock(clock), .levels(levels), .channel_q(channel_q),
        .tap_q(tap_q), .sample_q(sample_q), .hold_q(hold_q), .cmp_ge(cmp_ge));
    // ==========
    // Helpers
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic [1:0] op, input logic [15:0] a, input logic [15:0] d);
        @(posedge clock);
        cpu_req <= 1'b1;
        cpu_cmd <= '{op[1], op[0], a, d};
        @(negedge clock);
        t_take = cyc + 1;
        for (int k = 0; k < 4 && cpu_ack_q !== 1'b1; k++)
            @(negedge clock);
        rdat = cpu_rdata_q;
        check("bus ack", 16'h0001, {15'h0, cpu_ack_q});
        @(posedge clock);
        cpu_req <= 1'b0;
    endtask
    task automatic wait_irq(input int lim, output int at);
        at = -1;
        for (int k = 0; k < lim && at < 0; k++)
        begin
            @(negedge clock);
            if (irq === 1'b1)
                at = cyc;
        end
    endtask
    // ==========
    // Scenarios
    task automatic t_regs;
        bus(2'h0, sapf_pkg::CMPMODE_ADDR, 16'h0000);
        check("compare mode reset", 16'h0000, rdat);
        bus(2'h0, sapf_pkg::THRESH_ADDR, 16'h0000);
        check("threshold reset", 16'h0000, rdat);
        bus(2'h0, sapf_pkg::CHAN_ADDR, 16'h0000);
        check("channel reset", 16'h0000, rdat);
        bus(2'h2, sapf_pkg::CHAN_ADDR, 16'h00ff);
        bus(2'h0, sapf_pkg::CHAN_ADDR, 16'h0000);
        check("channel bits", 16'h0007, rdat);
        bus(2'h2, sapf_pkg::CMPMODE_ADDR, 16'h00ff);
        bus(2'h0, sapf_pkg::CMPMODE_ADDR, 16'h0000);
        check("compare mode bits", 16'h00c0, rdat);
        bus(2'h2, sapf_pkg::THRESH_ADDR, 16'h00a5);
        bus(2'h3, sapf_pkg::THRESH_ADDR, 16'h5a5a);
        bus(2'h0, sapf_pkg::THRESH_ADDR, 16'h0000);
        check("threshold byte only", 16'h00a5, rdat);
        bus(2'h1, sapf_pkg::CMPMODE_ADDR, 16'h0000);
        check("compare pair word", 16'ha5c0, rdat);
        bus(2'h3, sapf_pkg::MODE_ADDR, 16'hfdff);
        bus(2'h1, sapf_pkg::MODE_ADDR, 16'h0000);
        check("mode pair word", 16'h05b9, rdat);
        bus(2'h0, sapf_pkg::RESULT_HI_ADDR, 16'h0000);
        check("result byte read", 16'h0000, rdat);
        bus(2'h2, sapf_pkg::CMPMODE_ADDR, 16'h0000);
    endtask
    task automatic t_codes;
        logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
        int per [6] = '{288, 240, 192, 144, 120, 96};
        logic [9:0] lv [6] = '{10'h3ff, 10'h000, 10'h155, 10'h2aa, 10'h001, 10'h200};
        int at, t0;
        bus(2'h2, sapf_pkg::MODE_ADDR, 16'h0001);
        check("reference enable", 16'h0001, {15'h0, ref_q});
        repeat (350) @(negedge clock);
        for (int i = 0; i < 6; i++)
        begin
            levels[(i + 2) * 10 +: 10] <= lv[i];
            bus(2'h2, sapf_pkg::CHAN_ADDR, 16'(i + 2));
            bus(2'h2, sapf_pkg::MODE_ADDR, {8'h00, 2'b10, codes[i], 3'b001});
            t0 = t_take;
            wait_irq(400, at);
            check("conversion time", 16'(per[i]), 16'(at - t0));
            bus(2'h1, sapf_pkg::RESULT_ADDR, 16'h0000);
            check("result word", {lv[i], 6'h00}, rdat);
            t0 = at;
            wait_irq(400, at);
            check("repeat period", 16'(per[i]), 16'(at - t0));
            bus(2'h2, sapf_pkg::MODE_ADDR, 16'h0001);
        end
        for (int i = 0; i < 2; i++)
        begin
            bus(2'h2, sapf_pkg::MODE_ADDR, {8'h00, 2'b10, i[0], 2'b11, 3'b001});
            wait_irq(400, at);
            check("idle on bad code", 16'hffff, 16'(at));
        end
    endtask
    task automatic t_pf;
        logic [1:0] pol_exp [4] = '{2'b01, 2'b00, 2'b11, 2'b10};
        logic [9:0] lv [4] = '{10'h200, 10'h1ff, 10'h1ff, 10'h200};
        int at;
        for (int i = 0; i < 4; i++)
        begin
            levels[9:0] <= lv[i];
            bus(2'h2, sapf_pkg::CHAN_ADDR, 16'h0000);
            bus(2'h2, sapf_pkg::CMPMODE_ADDR, {8'h00, 1'b1, pol_exp[i][1], 6'h00});
            bus(2'h2, sapf_pkg::THRESH_ADDR, 16'h0080);
            bus(2'h2, sapf_pkg::MODE_ADDR, 16'h00b1);
            wait_irq(250, at);
            check("compare irq", {15'h0, pol_exp[i][0]}, {15'h0, at >= 0});
            bus(2'h2, sapf_pkg::MODE_ADDR, 16'h0001);
        end
        bus(2'h2, sapf_pkg::CMPMODE_ADDR, 16'h0000);
    endtask
    task automatic t_abort;
        int at, t0;
        levels[29:20] <= 10'h0f0;
        bus(2'h2, sapf_pkg::CHAN_ADDR, 16'h0002);
        bus(2'h2, sapf_pkg::MODE_ADDR, 16'h00b1);
        repeat (30) @(negedge clock);
        bus(2'h2, sapf_pkg::THRESH_ADDR, 16'h0011);
        t0 = t_take;
        wait_irq(200, at);
        check("restart after write", 16'h0060, 16'(at - t0));
        bus(2'h1, sapf_pkg::RESULT_ADDR, 16'h0000);
        check("result after restart", 16'h3c00, rdat);
        repeat (20) @(negedge clock);
        bus(2'h2, sapf_pkg::MODE_ADDR, 16'h0031);
        wait_irq(200, at);
        check("stop on run clear", 16'hffff, 16'(at));
    endtask
    // ==========
    // Run control
    task automatic close_out;
        if (miscompares == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        t_regs;
        t_codes;
        t_pf;
        t_abort;
        close_out;
    end
    initial
    begin
        #800000;
        miscompares++;
        close_out;
    end
endmodule // test_sapf_control
